/* common/ccd_map.svh */
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

// ==================== flag field positions ====================
`define FLAG_Z_BIT 0
`define FLAG_C_BIT 1
`define FLAG_V_BIT 2
`define FLAG_N_BIT 3
`define FLAGS_RESET 8'h00

// ==================== opcodes that are checked ====================
`define OPC_PREFIX_CF 8'hcf
`define OPC_DECR_BASE 8'h8c

// ==================== instruction cycles ====================
`define CYC_CMP_IMM 8'd3
`define CYC_CMP_SP_PAIR 8'd4
`define CYC_CMP_SP_IMM 8'd3
`define CYC_INV_REG 8'd3
`define CYC_INV_ABS 8'd5
`define CYC_INV_PAIR_IND 8'd4
`define CYC_DECR_REG 8'd2
`define CYC_DECR_BASE 8'd2

// ==================== memory access ticks ====================
`define TICK_MEM_READ 8'd1
`define TICK_MEM_CAPTURE 8'd2
`endif

/* common/ccd_pkg.sv */
package ccd_pkg;
	// ==================== operations ====================
	typedef enum logic [3:0] {
		OP_CMP_PAIR_IMM,
		OP_CMP_XIDX_IMM,
		OP_CMP_YIDX_IMM,
		OP_CMP_SP_PAIR,
		OP_CMP_SP_IMM,
		OP_INV_REG,
		OP_INV_ABS,
		OP_INV_PAIR_IND,
		OP_DECR_REG,
		OP_DECR_BASE
	} op_e;

	typedef enum logic [1:0] {R_A, R_B, R_L, R_H} reg8_e;
	typedef enum logic {BYTE_INVERT, BYTE_DECREMENT} byte_mode_e;

	// ==================== carriers ====================
	typedef struct packed {
		op_e op;
		logic [7:0] code_first;
		logic [7:0] code_second;
		reg8_e reg_sel;
		logic [15:0] imm16;
		logic [7:0] abs8_low_offset;
	} req_s;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] l;
		logic [7:0] h;
		logic [15:0] index_reg_x;
		logic [15:0] index_reg_y;
		logic [15:0] stack_ptr;
		logic [7:0] base_page;
		logic [7:0] expand_page;
		logic [7:0] system_condition_flags;
	} regs_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [23:0] addr;
		logic [7:0] wdata;
	} mem_s;
endpackage

/* design/sub16_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module sub16_flags (
	input wire logic [15:0] i_lhs,
	input wire logic [15:0] i_rhs,
	output logic [15:0] o_diff,
	output logic o_n,
	output logic o_v,
	output logic o_c,
	output logic o_z
);
	wire [16:0] wide_diff;

	// ==================== subtract and flags ====================
	// the extra top bit of the widened difference is the borrow
	assign wide_diff = {1'b0, i_lhs} - {1'b0, i_rhs};
	assign o_diff = wide_diff[15:0];
	assign o_n = wide_diff[15];
	assign o_c = wide_diff[16];
	assign o_z = (wide_diff[15:0] == 16'h0000);
	// overflow: operands differ in sign and result sign left the minuend's
	assign o_v = (i_lhs[15] ^ i_rhs[15]) & (i_lhs[15] ^ wide_diff[15]);
endmodule
`default_nettype wire

/* design/byte_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_unit
	import ccd_pkg::*;
(
	input wire logic [7:0] i_value,
	input wire byte_mode_e i_mode,
	output logic [7:0] o_result,
	output logic o_n,
	output logic o_z
);
	wire [7:0] inverted;
	wire [7:0] decremented;

	// ==================== byte operations ====================
	// both wrap in eight bits: zero decrements to all ones, no trap
	assign inverted = ~i_value;
	assign decremented = i_value - 8'h01;
	assign o_result = (i_mode == BYTE_DECREMENT) ? decremented : inverted;
	assign o_n = o_result[7];
	assign o_z = (o_result == 8'h00);
endmodule
`default_nettype wire

/* design/cmp_inv_decr.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccd_map.svh"
module cmp_inv_decr
	import ccd_pkg::*;
#(
	parameter int CLKS_PER_CYCLE = 2
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire req_s i_req,
	input wire regs_s i_regs,
	input wire logic i_banked_memory_models,
	input wire logic [7:0] i_mem_rdata,
	output logic o_busy,
	output logic o_done,
	output logic o_illegal,
	output logic [7:0] o_system_condition_flags,
	output logic o_flags_we,
	output logic o_reg8_we,
	output reg8_e o_reg8_sel,
	output logic [7:0] o_reg8_data,
	output logic o_base_we,
	output logic [7:0] o_base_data,
	output mem_s o_mem
);
	// ==================== elaboration checks ====================
	// memory ops need read, capture and write ticks; counter is 8 bits
	generate
		if (CLKS_PER_CYCLE < 2 || CLKS_PER_CYCLE > 50) begin : g_bad_rate
			$error("CLKS_PER_CYCLE must lie in 2..50");
		end
	endgenerate

	// ==================== helpers ====================
	function automatic logic [7:0] clks_of(input op_e op);
		logic [7:0] cyc;
		cyc = `CYC_CMP_IMM;
		case (op)
			OP_CMP_SP_PAIR: cyc = `CYC_CMP_SP_PAIR;
			OP_CMP_SP_IMM: cyc = `CYC_CMP_SP_IMM;
			OP_INV_REG: cyc = `CYC_INV_REG;
			OP_INV_ABS: cyc = `CYC_INV_ABS;
			OP_INV_PAIR_IND: cyc = `CYC_INV_PAIR_IND;
			OP_DECR_REG: cyc = `CYC_DECR_REG;
			OP_DECR_BASE: cyc = `CYC_DECR_BASE;
			default: cyc = `CYC_CMP_IMM;
		endcase
		return 8'(int'(cyc) * CLKS_PER_CYCLE);
	endfunction

	function automatic logic is_compare(input op_e op);
		return (op == OP_CMP_PAIR_IMM) || (op == OP_CMP_XIDX_IMM) || (op == OP_CMP_YIDX_IMM)
			|| (op == OP_CMP_SP_PAIR) || (op == OP_CMP_SP_IMM);
	endfunction

	function automatic logic is_memory(input op_e op);
		return (op == OP_INV_ABS) || (op == OP_INV_PAIR_IND);
	endfunction

	function automatic logic [7:0] pick_reg8(input regs_s r, input reg8_e sel);
		logic [7:0] v;
		v = r.a;
		case (sel)
			R_A: v = r.a;
			R_B: v = r.b;
			R_L: v = r.l;
			R_H: v = r.h;
			default: v = r.a;
		endcase
		return v;
	endfunction

	// ==================== state ====================
	typedef enum logic {ST_IDLE, ST_RUN} state_e;
	state_e state_reg;
	state_e state_next;
	logic [7:0] tick_reg;
	logic [7:0] tick_next;
	logic [7:0] total_reg;
	req_s req_reg;
	regs_s regs_reg;
	logic [7:0] mem_byte_reg;

	wire take;
	wire refuse;
	wire bad_code;
	wire run;
	wire fin;
	wire cmp_op;
	wire mem_op;
	wire [15:0] cmp_lhs;
	wire [15:0] cmp_rhs;
	wire [15:0] pair_sel;
	wire [15:0] cmp_diff;
	wire cmp_n;
	wire cmp_v;
	wire cmp_c;
	wire cmp_z;
	wire [7:0] byte_src;
	wire byte_mode_e byte_mode;
	wire [7:0] byte_res;
	wire byte_n;
	wire byte_z;
	logic [7:0] flags_new;
	wire [7:0] mem_page;
	wire [7:0] mem_hi;
	wire [7:0] mem_lo;
	wire req_s addr_req;
	wire regs_s addr_regs;

	// ==================== request intake ====================
	// stack-to-pair compare must carry the prefix; base decrement its own opcode
	assign bad_code = ((i_req.op == OP_CMP_SP_PAIR) && (i_req.code_first != `OPC_PREFIX_CF))
		|| ((i_req.op == OP_DECR_BASE) && (i_req.code_first != `OPC_DECR_BASE));
	assign take = (state_reg == ST_IDLE) && i_start && !bad_code;
	assign refuse = (state_reg == ST_IDLE) && i_start && bad_code;
	assign run = (state_reg == ST_RUN);
	assign fin = run && (tick_reg == total_reg - 8'd1);
	assign cmp_op = is_compare(req_reg.op);
	assign mem_op = is_memory(req_reg.op);

	// ==================== sequencing ====================
	// length counted in clocks so each op spans its full cycle count
	assign state_next = take ? ST_RUN : ((run && tick_reg == total_reg) ? ST_IDLE : state_reg);
	assign tick_next = take ? 8'd1 : (run ? tick_reg + 8'd1 : 8'd0);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
			tick_reg <= 8'd0;
			total_reg <= 8'd0;
		end else begin
			state_reg <= state_next;
			tick_reg <= tick_next;
			if (take) begin
				total_reg <= clks_of(i_req.op);
			end
		end
	end

	// operands frozen at intake so the whole op sees one snapshot
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			req_reg <= '0;
			regs_reg <= '0;
		end else if (take) begin
			req_reg <= i_req;
			regs_reg <= i_regs;
		end
	end

	// ==================== compare datapath ====================
	// select bit of the second opcode byte: 0 picks b:a, 1 picks h:l
	assign pair_sel = req_reg.code_second[0] ? {regs_reg.h, regs_reg.l}
		: {regs_reg.b, regs_reg.a};
	assign cmp_lhs = (req_reg.op == OP_CMP_XIDX_IMM) ? regs_reg.index_reg_x
		: (req_reg.op == OP_CMP_YIDX_IMM) ? regs_reg.index_reg_y
		: (req_reg.op == OP_CMP_PAIR_IMM) ? {regs_reg.h, regs_reg.l}
		: regs_reg.stack_ptr;
	assign cmp_rhs = (req_reg.op == OP_CMP_SP_PAIR) ? pair_sel : req_reg.imm16;

	sub16_flags u_sub (
		.i_lhs(cmp_lhs),
		.i_rhs(cmp_rhs),
		.o_diff(cmp_diff),
		.o_n(cmp_n),
		.o_v(cmp_v),
		.o_c(cmp_c),
		.o_z(cmp_z)
	);

	// ==================== byte datapath ====================
	assign byte_src = mem_op ? mem_byte_reg
		: (req_reg.op == OP_DECR_BASE) ? regs_reg.base_page
		: pick_reg8(regs_reg, req_reg.reg_sel);
	assign byte_mode = ((req_reg.op == OP_DECR_REG) || (req_reg.op == OP_DECR_BASE))
		? BYTE_DECREMENT : BYTE_INVERT;

	byte_unit u_byte (
		.i_value(byte_src),
		.i_mode(byte_mode),
		.o_result(byte_res),
		.o_n(byte_n),
		.o_z(byte_z)
	);

	// ==================== flag merge ====================
	// only the flags an op owns move; the top four are never touched
	always_comb begin
		flags_new = regs_reg.system_condition_flags;
		if (cmp_op) begin
			flags_new[`FLAG_N_BIT] = cmp_n;
			flags_new[`FLAG_V_BIT] = cmp_v;
			flags_new[`FLAG_C_BIT] = cmp_c;
			flags_new[`FLAG_Z_BIT] = cmp_z;
		end else if (byte_mode == BYTE_INVERT) begin
			flags_new[`FLAG_N_BIT] = byte_n;
			flags_new[`FLAG_Z_BIT] = byte_z;
		end else begin
			flags_new[`FLAG_Z_BIT] = byte_z;
		end
	end

	// ==================== memory access ====================
	// page only exists on banked parts; elsewhere it reads as zero
	// the read strobe leaves on the intake edge, before the frozen copy is loaded,
	// so the address then comes straight from the request
	assign addr_req = take ? i_req : req_reg;
	assign addr_regs = take ? i_regs : regs_reg;
	assign mem_page = i_banked_memory_models ? addr_regs.expand_page : 8'h00;
	assign mem_hi = (addr_req.op == OP_INV_ABS) ? addr_regs.base_page : addr_regs.h;
	assign mem_lo = (addr_req.op == OP_INV_ABS) ? addr_req.abs8_low_offset : addr_regs.l;

	// read strobe in tick 1, data taken at end of tick 2, write in last tick
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mem <= '0;
			mem_byte_reg <= 8'h00;
		end else begin
			o_mem.rd <= take && is_memory(i_req.op);
			o_mem.wr <= fin && mem_op;
			o_mem.wdata <= (fin && mem_op) ? byte_res : 8'h00;
			o_mem.addr <= {mem_page, mem_hi, mem_lo};
			if (run && mem_op && tick_reg == `TICK_MEM_CAPTURE) begin
				mem_byte_reg <= i_mem_rdata;
			end
		end
	end

	// ==================== results ====================
	// compares never raise a register write: source stays untouched
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_illegal <= 1'b0;
			o_system_condition_flags <= `FLAGS_RESET;
			o_flags_we <= 1'b0;
			o_reg8_we <= 1'b0;
			o_reg8_sel <= R_A;
			o_reg8_data <= 8'h00;
			o_base_we <= 1'b0;
			o_base_data <= 8'h00;
		end else begin
			o_busy <= (state_next == ST_RUN);
			o_done <= fin;
			o_illegal <= refuse;
			o_flags_we <= fin;
			o_reg8_we <= fin && ((req_reg.op == OP_INV_REG) || (req_reg.op == OP_DECR_REG));
			o_base_we <= fin && (req_reg.op == OP_DECR_BASE);
			if (fin) begin
				o_system_condition_flags <= flags_new;
				o_reg8_sel <= req_reg.reg_sel;
				o_reg8_data <= byte_res;
				o_base_data <= byte_res;
			end
		end
	end

	// ==================== checks ====================
	localparam int LEN_CMP3 = 3 * CLKS_PER_CYCLE - 1;
	localparam int LEN_INV5 = 5 * CLKS_PER_CYCLE - 1;
	localparam int LEN_INV4 = 4 * CLKS_PER_CYCLE - 1;
	localparam int LEN_DEC2 = 2 * CLKS_PER_CYCLE - 1;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_cmp_pair_len: assert property ($rose(o_busy) && req_reg.op == OP_CMP_PAIR_IMM
		|-> ##[LEN_CMP3:LEN_CMP3] (o_done && !o_reg8_we && !o_base_we && !o_mem.wr))
		else $error("pair compare length or side write wrong");
	a_cmp_flag_math: assert property (o_flags_we && cmp_op
		|-> o_system_condition_flags[`FLAG_N_BIT] == cmp_diff[15]
		&& o_system_condition_flags[`FLAG_Z_BIT] == (cmp_lhs == cmp_rhs)
		&& o_system_condition_flags[`FLAG_C_BIT] == (cmp_lhs < cmp_rhs))
		else $error("compare flags disagree with difference");
	a_ctrl_flags_kept: assert property (o_flags_we
		|-> o_system_condition_flags[7:4] == regs_reg.system_condition_flags[7:4])
		else $error("control flags changed");
	a_xidx_cmp_len: assert property ($rose(o_busy) && req_reg.op == OP_CMP_XIDX_IMM
		|-> !o_reg8_we throughout (##[LEN_CMP3:LEN_CMP3] o_done))
		else $error("x index compare length wrong");
	a_sp_prefix_chk: assert property (i_start && !o_busy && i_req.op == OP_CMP_SP_PAIR
		&& i_req.code_first != `OPC_PREFIX_CF |=> o_illegal && !o_busy)
		else $error("bad prefix not refused");
	a_inv_reg_vc: assert property (o_flags_we && req_reg.op == OP_INV_REG
		|-> o_reg8_data == ~pick_reg8(regs_reg, req_reg.reg_sel)
		&& o_system_condition_flags[2:1] == regs_reg.system_condition_flags[2:1])
		else $error("register invert wrong");
	a_inv_abs_write: assert property ($rose(o_busy) && req_reg.op == OP_INV_ABS
		|-> ##[LEN_INV5:LEN_INV5] (o_mem.wr && o_mem.addr[15:0]
		== {regs_reg.base_page, req_reg.abs8_low_offset} && o_mem.wdata == ~mem_byte_reg))
		else $error("absolute invert write wrong");
	a_inv_ind_write: assert property ($rose(o_busy) && req_reg.op == OP_INV_PAIR_IND
		|-> ##[LEN_INV4:LEN_INV4] (o_mem.wr && (!i_banked_memory_models
		|| o_mem.addr[23:16] == regs_reg.expand_page)))
		else $error("indirect invert write wrong");
	a_decr_z_only: assert property (o_flags_we && req_reg.op == OP_DECR_REG
		|-> o_system_condition_flags[3:1] == regs_reg.system_condition_flags[3:1]
		&& o_reg8_data == pick_reg8(regs_reg, req_reg.reg_sel) - 8'h01)
		else $error("register decrement wrong");
	a_decr_base_len: assert property ($rose(o_busy) && req_reg.op == OP_DECR_BASE
		|-> ##[LEN_DEC2:LEN_DEC2] (o_base_we && o_base_data == regs_reg.base_page - 8'h01))
		else $error("base decrement wrong");

	c_cmp_borrow: cover property (o_flags_we && cmp_op && cmp_c && cmp_v);
	c_inv_mem: cover property (o_mem.wr && req_reg.op == OP_INV_ABS);
	c_decr_wrap: cover property (o_reg8_we && o_reg8_data == 8'hff);
endmodule
`default_nettype wire

/* verification/compare_complement_decrement_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module compare_complement_decrement_tb_top
	import ccd_pkg::*;
;
	// ==================== signals ====================
	logic i_clk, i_rst_n, i_start, i_banked_memory_models;
	req_s i_req;
	regs_s i_regs;
	logic [7:0] i_mem_rdata, mem_byte, v, nv, f, pg;
	logic o_busy, o_done, o_illegal, o_flags_we, o_reg8_we, o_base_we;
	logic [7:0] o_system_condition_flags, o_reg8_data, o_base_data;
	reg8_e o_reg8_sel;
	mem_s o_mem;
	logic [23:0] rd_addr;
	int n_mismatch, check_count, cycles;
	req_s r;
	regs_s g;
	logic [15:0] lhs [4] = '{16'h3f71, 16'h53d1, 16'ha291, 16'h2862};
	logic [15:0] rhs [4] = '{16'h145a, 16'h53d1, 16'h632e, 16'h4c25};
	logic [7:0] vals [3] = '{8'hff, 8'h01, 8'h00};
	op_e ops [6] = '{OP_CMP_PAIR_IMM, OP_CMP_XIDX_IMM, OP_CMP_YIDX_IMM, OP_CMP_SP_IMM,
		OP_CMP_SP_PAIR, OP_CMP_SP_PAIR};

	cmp_inv_decr u_cmp_inv_decr (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_req(i_req),
		.i_regs(i_regs), .i_banked_memory_models(i_banked_memory_models),
		.i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_done(o_done),
		.o_illegal(o_illegal), .o_system_condition_flags(o_system_condition_flags),
		.o_flags_we(o_flags_we), .o_reg8_we(o_reg8_we), .o_reg8_sel(o_reg8_sel),
		.o_reg8_data(o_reg8_data), .o_base_we(o_base_we), .o_base_data(o_base_data),
		.o_mem(o_mem)
	);

	// ==================== clock, memory and watchdog ====================
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// memory answers one clock after the read strobe; otherwise it shows the inverse
	// so a late capture cannot pass by luck
	always @(posedge i_clk) begin
		i_mem_rdata <= o_mem.rd ? mem_byte : ~mem_byte;
		if (o_mem.rd) rd_addr <= o_mem.addr;
	end

	// about 540 clocks are needed; the ceiling leaves ample margin
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// ==================== helpers ====================
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// compare flags: N sign, V signed overflow, C borrow, Z zero; control bits kept
	function automatic logic [7:0] cmp_f(input logic [7:0] fl, input logic [15:0] a,
		input logic [15:0] b);
		logic [15:0] d;
		d = a - b;
		return {fl[7:4], d[15], (a[15] != b[15]) && (d[15] != a[15]), a < b, d == 16'h0};
	endfunction

	// one request, then wait for completion and check every result at the done clock
	task automatic do_op(input int cyc, input logic [7:0] ef, input logic rwe,
		input logic [7:0] rd, input logic bwe, input logic [7:0] bd, input logic mwr,
		input logic [23:0] ma, input logic [7:0] md);
		int k;
		@(posedge i_clk);
		i_start <= 1'b1;
		i_req <= r;
		i_regs <= g;
		@(posedge i_clk);
		i_start <= 1'b0;
		for (k = 1; k < 100; k++) begin
			#1;
			if (o_done === 1'b1) break;
			@(posedge i_clk);
		end
		check(k, 2 * cyc);
		check({o_flags_we, o_system_condition_flags}, {1'b1, ef});
		check({o_reg8_we, o_base_we, o_mem.wr}, {rwe, bwe, mwr});
		if (rwe) check({o_reg8_sel, o_reg8_data}, {r.reg_sel, rd});
		if (bwe) check(o_base_data, bd);
		if (mwr) check({rd_addr, o_mem.addr, o_mem.wdata}, {ma, ma, md});
	endtask

	// a refused request pulses the illegal flag and completes nothing
	task automatic do_bad();
		@(posedge i_clk);
		i_start <= 1'b1;
		i_req <= r;
		@(posedge i_clk);
		i_start <= 1'b0;
		#1;
		check({o_illegal, o_busy}, 2'b10);
		repeat (10) begin
			@(posedge i_clk);
			#1;
			check({o_done, o_flags_we, o_busy}, 3'b000);
		end
	endtask

	// ==================== main sequence ====================
	initial begin
		i_rst_n = 1'b0;
		i_start = 1'b0;
		i_req = '0;
		i_regs = '0;
		i_banked_memory_models = 1'b0;
		mem_byte = 8'h00;
		n_mismatch = 0;
		check_count = 0;
		r = '0;
		g = '0;
		repeat (2) @(posedge i_clk);
		#1;
		check({o_busy, o_done, o_system_condition_flags, o_mem}, '0);
		@(posedge i_clk);
		i_rst_n <= 1'b1;
		// compares: only the chosen registers match the table, the other registers are decoys
		g.system_condition_flags = 8'ha5;
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 6; j++) begin
				g.stack_ptr = (j >= 3) ? lhs[i] : ~lhs[i];
				g.index_reg_x = (j == 1) ? lhs[i] : ~lhs[i];
				g.index_reg_y = (j == 2) ? lhs[i] : ~lhs[i];
				{g.h, g.l} = (j == 0) ? lhs[i] : (j == 5) ? rhs[i] : ~rhs[i];
				{g.b, g.a} = (j == 4) ? rhs[i] : ~rhs[i];
				r.op = ops[j];
				r.imm16 = rhs[i];
				r.code_first = 8'hcf;
				r.code_second = (j == 4) ? 8'h5c : 8'h5d;
				do_op((j > 3) ? 4 : 3, cmp_f(8'ha5, lhs[i], rhs[i]), 0, 0, 0, 0, 0, 0, 0);
			end
		end
		// refused codes: one bit off the required opcode
		r.op = OP_CMP_SP_PAIR;
		r.code_first = 8'hce;
		do_bad();
		r.op = OP_DECR_BASE;
		r.code_first = 8'h8d;
		do_bad();
		// register invert and decrement, base decrement, wrap at zero
		f = 8'h9e;
		g.system_condition_flags = f;
		r.code_first = 8'h8c;
		for (int i = 0; i < 4; i++) begin
			for (int k = 0; k < 3; k++) begin
				v = vals[k];
				nv = ~v;
				{g.h, g.l, g.b, g.a} = 32'h44332211;
				case (i)
					0: g.a = v;
					1: g.b = v;
					2: g.l = v;
					default: g.h = v;
				endcase
				g.base_page = v;
				r.reg_sel = reg8_e'(i);
				r.op = OP_INV_REG;
				do_op(3, {f[7:4], nv[7], f[2:1], nv == 8'h00}, 1, nv, 0, 0, 0, 0, 0);
				r.op = OP_DECR_REG;
				do_op(2, {f[7:1], v == 8'h01}, 1, v - 8'h01, 0, 0, 0, 0, 0);
				r.op = OP_DECR_BASE;
				do_op(2, {f[7:1], v == 8'h01}, 0, 0, 1, v - 8'h01, 0, 0, 0);
			end
		end
		// memory inverts with and without the banked page
		g.base_page = 8'h3c;
		g.expand_page = 8'h41;
		{g.h, g.l} = 16'h9a0f;
		r.abs8_low_offset = 8'h7e;
		for (int m = 0; m < 2; m++) begin
			for (int k = 0; k < 3; k++) begin
				@(posedge i_clk);
				i_banked_memory_models <= m[0];
				mem_byte = vals[k];
				nv = ~vals[k];
				pg = m[0] ? 8'h41 : 8'h00;
				r.op = OP_INV_ABS;
				do_op(5, {f[7:4], nv[7], f[2:1], nv == 8'h00}, 0, 0, 0, 0, 1,
					{pg, 8'h3c, 8'h7e}, nv);
				r.op = OP_INV_PAIR_IND;
				do_op(4, {f[7:4], nv[7], f[2:1], nv == 8'h00}, 0, 0, 0, 0, 1,
					{pg, 8'h9a, 8'h0f}, nv);
			end
		end
		repeat (2) @(posedge i_clk);
		finish_test();
	end
endmodule
`default_nettype wire
